// File: scbr_device.sv
// Function
// - Reset level clears counter, floats data
// - Select high after reset freezes counter
// - Select low enables counter and data
// - Reset clears counter regardless of select
// - Power-up clears the address counter
// - Clock rise advances counter, next bit
// - Count only when enabled; master clock low
// - Reset stops oscillator, clock pin low
// - Reset pin polarity is stored setting
// - Role latched from select at release
// - Cascade low after a clock rise at counter maximum
// - Edge after last bit cascades, floats data
// - Subsequent device enables on select low
// - Cascade output feeds next select
// - Data feeds FPGA; FPGA drives clock
// - Program enable held high for loading
// - Reset after configuration clears counters
// - Ready pulled low during power-up
// - Block protect refuses lowest block writes
// - Select high means standby, data floats
`timescale 1ns/1ps
`default_nettype none
module scbr_device
  import scbr_pkg::*;
(
  input  wire logic          clk,
  input  wire logic          reset,
  scbr_link_if.device        link,
  input  wire logic          partial_write_protect,
  input  wire logic          program_device_select,
  input  wire logic          prog_we,
  input  wire logic [SCBR_ADDR_W-1:0] prog_addr,
  input  wire logic          prog_bit,
  output logic               master_clock_out,
  output logic               is_master,
  output logic               powered_up,
  output logic               standby,
  output logic               prog_refused
);
  logic                   mem_q [SCBR_DEPTH];
  logic [SCBR_ADDR_W-1:0] addr_q;
  logic                   done_q;
  logic [4:0]             por_q;
  logic                   powered_q;
  logic                   ready_oe_n_q;
  scbr_role_t             role_q;
  logic                   master_q;
  logic                   standby_q;
  logic [1:0]             div_q;
  logic                   data_q;
  logic                   data_oe_n_q;
  logic                   casc_n_q;
  logic                   mclk_q;
  logic                   refused_q;
  logic                   clk_rise;
  logic                   in_reset;
  logic                   loading;
  logic                   selected;
  logic                   count_en;
  logic                   rst_rel;
  logic                   protect_hit;

  // ------------------------------------------------------------
  // Pin decoding
  // ------------------------------------------------------------
  assign loading  = link.serial_program_enable_n;
  // Stored polarity picks which level resets
  assign in_reset = (link.reset_oe != SCBR_POL_RESET_LOW) | ~powered_q;
  assign selected = ~link.chip_select_n;
  assign count_en = loading & ~in_reset & selected & ~done_q;

  // Rising edges of the serial clock and of reset release
  scbr_edge_det u_clk_edge (
    .clk   (clk),
    .reset (reset),
    .level (link.serial_config_clock),
    .rise  (clk_rise)
  );

  scbr_edge_det u_rst_edge (
    .clk   (clk),
    .reset (reset),
    .level (~in_reset),
    .rise  (rst_rel)
  );

  // ------------------------------------------------------------
  // Power-on reset sequence
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      por_q <= SCBR_POR_RST;
    end else if (por_q != SCBR_POR_LAST) begin
      por_q <= por_q + 5'h01;
    end
  end

  // Power-up flag, set once the count is spent
  always_ff @(posedge clk) begin
    if (reset) begin
      powered_q <= 1'b0;
    end else begin
      powered_q <= (por_q == SCBR_POR_LAST);
    end
  end

  // Ready pulled low until power-up completes
  always_ff @(posedge clk) begin
    if (reset) begin
      ready_oe_n_q <= 1'b0;
    end else begin
      ready_oe_n_q <= powered_q;
    end
  end

  // ------------------------------------------------------------
  // Role latched at reset release
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      role_q   <= SCBR_ROLE_MASTER;
      master_q <= 1'b1;
    end else if (rst_rel) begin
      role_q <= link.chip_select_n ? SCBR_ROLE_SUBSEQ
                                   : SCBR_ROLE_MASTER;
      master_q <= ~link.chip_select_n;
    end
  end

  // Standby follows the select pin
  always_ff @(posedge clk) begin
    if (reset) begin
      standby_q <= 1'b1;
    end else begin
      standby_q <= link.chip_select_n;
    end
  end

  // ------------------------------------------------------------
  // Address counter
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || in_reset) begin
      addr_q <= SCBR_ADDR_RST;
      done_q <= 1'b0;
    end else if (clk_rise && count_en) begin
      if (addr_q == SCBR_ADDR_MAX) begin
        done_q <= 1'b1;
      end else begin
        addr_q <= addr_q + 10'h001;
      end
    end
  end

  // ------------------------------------------------------------
  // Data driver and cascade output
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      data_q      <= 1'b0;
      data_oe_n_q <= 1'b1;
    end else begin
      data_q      <= mem_q[addr_q];
      // Drive only when enabled and data remains
      data_oe_n_q <= ~(loading & ~in_reset
                       & selected & ~done_q);
    end
  end

  // Cascade low once the memory is spent
  always_ff @(posedge clk) begin
    if (reset) begin
      casc_n_q <= 1'b1;
    end else begin
      casc_n_q <= ~(~in_reset & done_q);
    end
  end

  // ------------------------------------------------------------
  // Internal oscillator (master role)
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || in_reset || !count_en || role_q != SCBR_ROLE_MASTER) begin
      div_q  <= SCBR_DIV_RST;
      mclk_q <= 1'b0;
    end else if (div_q == SCBR_DIV_LAST) begin
      div_q  <= SCBR_DIV_RST;
      mclk_q <= ~mclk_q;
    end else begin
      div_q  <= div_q + 2'h1;
    end
  end

  // ------------------------------------------------------------
  // Programming mode writes
  // ------------------------------------------------------------
  assign protect_hit = partial_write_protect &&
                       prog_addr[SCBR_ADDR_W-1:SCBR_ADDR_W-2] == 2'h0;

  // Write port, programming mode only
  always_ff @(posedge clk) begin
    if (!loading && program_device_select && prog_we && !protect_hit) begin
      mem_q[prog_addr] <= prog_bit;
    end
  end

  // One-cycle flag for a refused write
  always_ff @(posedge clk) begin
    if (reset) begin
      refused_q <= 1'b0;
    end else begin
      refused_q <= ~loading & program_device_select & prog_we
                   & protect_hit;
    end
  end

  // ------------------------------------------------------------
  // Output assignments
  // ------------------------------------------------------------
  assign link.data_o        = data_q;
  assign link.data_oe_n     = data_oe_n_q;
  assign link.cascade_out_n = casc_n_q;
  assign link.ready_oe_n    = ready_oe_n_q;
  assign master_clock_out   = mclk_q;
  assign is_master          = master_q;
  assign powered_up         = powered_q;
  assign standby            = standby_q;
  assign prog_refused       = refused_q;
endmodule // scbr_device
`default_nettype wire

// File: scbr_pkg.sv
package scbr_pkg;

  // ----------------------------------------------------------------
  // Memory geometry
  // ----------------------------------------------------------------
  localparam int unsigned SCBR_ADDR_W = 10;
  localparam int unsigned SCBR_DEPTH  = 1024;
  localparam logic [SCBR_ADDR_W-1:0] SCBR_ADDR_RST = 10'h000;
  localparam logic [SCBR_ADDR_W-1:0] SCBR_ADDR_MAX = 10'h3FF;

  // ----------------------------------------------------------------
  // Power-up and clock generation
  // ----------------------------------------------------------------
  localparam int unsigned SCBR_POR_CYCLES = 16;
  localparam logic [4:0]  SCBR_POR_RST    = 5'h00;
  localparam logic [4:0]  SCBR_POR_LAST   = 5'h0F;
  localparam int unsigned SCBR_CLK_HALF   = 2;
  localparam logic [1:0]  SCBR_DIV_RST    = 2'h0;
  localparam logic [1:0]  SCBR_DIV_LAST   = 2'h1;

  // Reset pin polarity setting: 1 = low resets, high enables output
  localparam logic SCBR_POL_RESET_LOW = 1'b1;

  // Role latched at reset release
  typedef enum logic {
    SCBR_ROLE_MASTER,
    SCBR_ROLE_SUBSEQ
  } scbr_role_t;

  // Host sequence states
  typedef enum logic [1:0] {
    SCBR_H_IDLE,
    SCBR_H_RESET,
    SCBR_H_LOAD,
    SCBR_H_DONE
  } scbr_hstate_t;

endpackage : scbr_pkg

// File: scbr_link_if.sv
`timescale 1ns/1ps
`default_nettype none
interface scbr_link_if;
  logic serial_config_clock;     // Clock to the memory (master FPGA)
  logic reset_oe;                // Reset level / output enable
  logic chip_select_n;           // Chip select, low active
  logic serial_program_enable_n; // High for loading
  logic data_o;                  // Memory data output value
  logic data_oe_n;               // Low while memory drives data
  logic cascade_out_n;           // Cascade output, low active
  logic ready_oe_n;              // Low while ready is pulled low
  logic data_line;               // Resolved data wire

  // Resolve data wire; a released line floats high via pull-up
  assign data_line = data_oe_n ? 1'b1 : data_o;

  modport device (
    input  serial_config_clock,
    input  reset_oe,
    input  chip_select_n,
    input  serial_program_enable_n,
    output data_o,
    output data_oe_n,
    output cascade_out_n,
    output ready_oe_n
  );

  modport host (
    output serial_config_clock,
    output reset_oe,
    output chip_select_n,
    output serial_program_enable_n,
    input  data_line,
    input  data_oe_n,
    input  cascade_out_n,
    input  ready_oe_n
  );
endinterface : scbr_link_if
`default_nettype wire

// File: scbr_edge_det.sv
`timescale 1ns/1ps
`default_nettype none
module scbr_edge_det
  import scbr_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  input  wire logic level,
  output logic      rise
);
  logic prev_q;

  // Remember previous level
  always_ff @(posedge clk) begin
    if (reset) begin
      prev_q <= 1'b0;
    end else begin
      prev_q <= level;
    end
  end

  // High in the cycle the level first shows high
  assign rise = level & ~prev_q;
endmodule // scbr_edge_det
`default_nettype wire

// File: scbr_host.sv
`timescale 1ns/1ps
`default_nettype none
module scbr_host
  import scbr_pkg::*;
(
  input  wire logic clk,
  input  wire logic reset,
  scbr_link_if.host link,
  input  wire logic start,
  input  wire logic program_mode,
  output logic      bit_valid,
  output logic      bit_value,
  output logic      busy,
  output logic      done
);
  scbr_hstate_t state_q;
  logic         sclk_q;
  logic         rst_q;
  logic [1:0]   div_q;
  logic         valid_q;
  logic         bit_q;
  logic         cs_n_q;
  logic         pen_n_q;
  logic         done_q;

  // ------------------------------------------------------------
  // Load sequence
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset) begin
      state_q <= SCBR_H_IDLE;
    end else begin
      unique case (state_q)
        SCBR_H_IDLE:  if (start && link.ready_oe_n) state_q <= SCBR_H_RESET;
        SCBR_H_RESET: state_q <= SCBR_H_LOAD;
        SCBR_H_LOAD:  if (!link.cascade_out_n) state_q <= SCBR_H_DONE;
        SCBR_H_DONE:  state_q <= SCBR_H_IDLE;
      endcase
    end
  end

  // Reset low while idle, high through reset and load states, then low again after configuration
  always_ff @(posedge clk) begin
    if (reset) begin
      rst_q  <= 1'b0;
      cs_n_q <= 1'b1;
    end else begin
      rst_q <= (state_q == SCBR_H_LOAD) ||
               (state_q == SCBR_H_RESET);
      cs_n_q <= (state_q != SCBR_H_LOAD) &&
                (state_q != SCBR_H_RESET);
    end
  end

  // Done pulse and program enable, registered
  always_ff @(posedge clk) begin
    if (reset) begin
      done_q  <= 1'b0;
      pen_n_q <= 1'b1;
    end else begin
      done_q  <= (state_q == SCBR_H_LOAD) && !link.cascade_out_n;
      pen_n_q <= ~program_mode;
    end
  end

  // ------------------------------------------------------------
  // Serial clock divider
  // ------------------------------------------------------------
  always_ff @(posedge clk) begin
    if (reset || state_q != SCBR_H_LOAD) begin
      div_q  <= SCBR_DIV_RST;
      sclk_q <= 1'b0;
    end else if (div_q == SCBR_DIV_LAST) begin
      div_q  <= SCBR_DIV_RST;
      sclk_q <= ~sclk_q;
    end else begin
      div_q  <= div_q + 2'h1;
    end
  end

  // Sample data just before each rising clock edge
  always_ff @(posedge clk) begin
    if (reset) begin
      valid_q <= 1'b0;
      bit_q   <= 1'b0;
    end else begin
      valid_q <= (state_q == SCBR_H_LOAD) && !sclk_q &&
                 div_q == SCBR_DIV_LAST && !link.data_oe_n;
      bit_q   <= link.data_line;
    end
  end

  assign link.serial_config_clock     = sclk_q;
  assign link.reset_oe                = rst_q;
  assign link.chip_select_n           = cs_n_q;
  assign link.serial_program_enable_n = pen_n_q;
  assign bit_valid = valid_q;
  assign bit_value = bit_q;
  assign busy      = rst_q;
  assign done      = done_q;
endmodule // scbr_host
`default_nettype wire

// File: scbr_checker.sv
`timescale 1ns/1ps
`default_nettype none
// ----------------------------------------
// Link checker
// ----------------------------------------
module scbr_checker (
  input wire logic clk,
  input wire logic reset,
  input wire logic serial_config_clock,
  input wire logic reset_oe,
  input wire logic chip_select_n,
  input wire logic serial_program_enable_n,
  input wire logic data_oe_n,
  input wire logic cascade_out_n,
  input wire logic ready_oe_n
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (reset);

  // Data driver released in reset, after the end and in power-up
  a_reset_floats_data: assert property (
    (!reset_oe && serial_program_enable_n) [*2] |-> data_oe_n)
    else $error("data driven while reset level held");
  a_cascade_floats_data: assert property (
    !cascade_out_n [*2] |-> data_oe_n)
    else $error("data driven after cascade");
  a_standby_floats_data: assert property (
    chip_select_n |=> data_oe_n)
    else $error("data driven while deselected");
  a_powerup_no_drive: assert property (
    !ready_oe_n |-> data_oe_n)
    else $error("data driven during power-up");

  // Cascade stands until the reset level
  a_cascade_holds_low: assert property (
    !cascade_out_n && reset_oe && serial_program_enable_n
      |=> !cascade_out_n)
    else $error("cascade released early");

  // Ready indicator around power-up
  a_ready_low_powerup: assert property (
    $fell(reset) |-> !ready_oe_n [*8])
    else $error("ready released too early");
  a_ready_release_bound: assert property (
    $fell(reset) |-> ##[8:40] ready_oe_n)
    else $error("ready never released");
  a_ready_stays_out: assert property (
    ready_oe_n |=> ready_oe_n)
    else $error("ready pulled low again");

  // Serial clock levels last two cycles each
  a_sclk_min_high: assert property (
    $rose(serial_config_clock) |=> serial_config_clock)
    else $error("serial clock high too short");
  a_sclk_min_low: assert property (
    $fell(serial_config_clock) |=> !serial_config_clock)
    else $error("serial clock low too short");
endmodule // scbr_checker
`default_nettype wire

// File: serial_config_bitstream_readout_tb_top.sv
`timescale 1ns/1ps
`default_nettype none
module serial_config_bitstream_readout_tb_top;
  import scbr_pkg::*;
  // ----------------------------------------
  // Bench signals and two chained memories
  // ----------------------------------------
  logic                   clk, reset, start, program_mode, protect;
  logic                   prog_we, prog_bit, refused, bit_valid;
  logic                   bit_value, done, mclk, master_a, master_b, powered;
  logic                   standby_a, busy;
  logic [SCBR_ADDR_W-1:0] prog_addr;
  int                     error_cnt, n_compared;
  scbr_link_if i_link ();
  scbr_link_if i_link_b ();

  // Second memory hangs off the first one's cascade output
  assign i_link_b.serial_config_clock = i_link.serial_config_clock;
  assign i_link_b.reset_oe = i_link.reset_oe;
  assign i_link_b.chip_select_n = i_link.cascade_out_n;
  assign i_link_b.serial_program_enable_n = i_link.serial_program_enable_n;

  scbr_device i_scbr_device (
    .clk(clk), .reset(reset), .link(i_link.device),
    .partial_write_protect(protect), .program_device_select(1'h1),
    .prog_we(prog_we), .prog_addr(prog_addr), .prog_bit(prog_bit),
    .master_clock_out(mclk), .is_master(master_a), .powered_up(powered),
    .standby(standby_a), .prog_refused(refused));
  scbr_device i_scbr_device_b (
    .clk(clk), .reset(reset), .link(i_link_b.device),
    .partial_write_protect(protect), .program_device_select(1'h0),
    .prog_we(prog_we), .prog_addr(prog_addr), .prog_bit(prog_bit),
    .master_clock_out(), .is_master(master_b), .powered_up(),
    .standby(), .prog_refused());
  scbr_host i_scbr_host (
    .clk(clk), .reset(reset), .link(i_link.host), .start(start),
    .program_mode(program_mode), .bit_valid(bit_valid),
    .bit_value(bit_value), .busy(busy), .done(done));
  scbr_checker i_scbr_checker (
    .clk(clk), .reset(reset),
    .serial_config_clock(i_link.serial_config_clock),
    .reset_oe(i_link.reset_oe),
    .chip_select_n(i_link.chip_select_n),
    .serial_program_enable_n(i_link.serial_program_enable_n),
    .data_oe_n(i_link.data_oe_n), .cascade_out_n(i_link.cascade_out_n),
    .ready_oe_n(i_link.ready_oe_n));

  // 100 MHz clock
  always #5 clk = ~clk;

  // Compare and count
  task automatic chk(input string nm, input logic [10:0] e,
                     input logic [10:0] g);
    n_compared++;
    if (g !== e) begin
      error_cnt++;
      $display("ERROR %s expected %0h seen %0h", nm, e, g);
    end
  endtask

  // Counts, verdict, end of run
  task automatic report_and_stop();
    $display("compared %0d errors %0d", n_compared, error_cnt);
    if (error_cnt == 0 && n_compared > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask

  // Stored pattern for each address
  function automatic logic pat(input logic [SCBR_ADDR_W-1:0] a);
    return ^(a & 10'h2C5);
  endfunction

  // One programming write, watching for a refusal
  task automatic prog_wr(input logic [SCBR_ADDR_W-1:0] a, input logic b,
                         output logic seen);
    seen = 1'h0;
    prog_we <= 1'h1;
    prog_addr <= a;
    prog_bit <= b;
    @(posedge clk);
    prog_we <= 1'h0;
    repeat (4) begin
      @(posedge clk);
      seen |= refused;
    end
  endtask

  // Ready low, then released; data floating
  task automatic t_powerup();
    chk("ready_oe_n", 1'h0, i_link.ready_oe_n);
    for (int i = 0; i < 64 && i_link.ready_oe_n !== 1'h1; i++) @(posedge clk);
    repeat (2) @(posedge clk);
    chk("powered_up", 1'h1, powered);
    chk("data_oe_n", 1'h1, i_link.data_oe_n);
    chk("standby", 1'h1, standby_a);
  endtask

  // Program the pattern, then probe both sides of the protected block
  task automatic t_program();
    logic seen;
    program_mode <= 1'h1;
    repeat (4) @(posedge clk);
    chk("prog_en_n", 1'h0, i_link.serial_program_enable_n);
    for (int a = 0; a < SCBR_DEPTH; a++) begin
      prog_wr(a[SCBR_ADDR_W-1:0], pat(a[SCBR_ADDR_W-1:0]), seen);
      chk("refused_open", 1'h0, seen);
    end
    protect <= 1'h1;
    prog_wr(10'h005, ~pat(10'h005), seen);
    chk("refused_low", 1'h1, seen);
    prog_wr(10'h12C, pat(10'h12C), seen);
    chk("refused_high", 1'h0, seen);
    protect <= 1'h0;
    program_mode <= 1'h0;
    repeat (4) @(posedge clk);
  endtask

  // Full read-out and handoff to the chained memory
  task automatic t_load();
    logic [10:0] n;
    n = 11'h000;
    start <= 1'h1;
    @(posedge clk);
    start <= 1'h0;
    for (int i = 0; i < 50 && i_link.reset_oe !== 1'h0; i++) @(posedge clk);
    chk("mclk_reset", 1'h0, mclk);
    for (int i = 0; i < 9000 && done !== 1'h1; i++) begin
      @(posedge clk);
      if (bit_valid === 1'h1) begin
        chk("bit", pat(n[9:0]), bit_value);
        chk("b_oe_n", 1'h1, i_link_b.data_oe_n);
        chk("busy", 1'h1, busy);
        n++;
      end
    end
    chk("bit_count", 11'h400, n);
    chk("master_a", 1'h1, master_a);
    chk("master_b", 1'h0, master_b);
    for (int i = 0; i < 8 && i_link.cascade_out_n !== 1'h0; i++)
      @(posedge clk);
    chk("cascade", 1'h0, i_link.cascade_out_n);
    @(posedge clk);
    chk("oe_n_end", 1'h1, i_link.data_oe_n);
    for (int i = 0; i < 8 && i_link_b.data_oe_n !== 1'h0; i++) @(posedge clk);
    chk("b_drives", 1'h0, i_link_b.data_oe_n);
    chk("mclk_end", 1'h0, mclk);
  endtask

  // Watchdog
  initial begin
    repeat (40000) @(posedge clk);
    error_cnt++;
    report_and_stop();
  end

  // Main sequence
  initial begin
    clk = 1'h0;
    reset = 1'h1;
    start = 1'h0;
    program_mode = 1'h0;
    protect = 1'h0;
    prog_we = 1'h0;
    prog_bit = 1'h0;
    prog_addr = 10'h000;
    error_cnt = 0;
    n_compared = 0;
    repeat (4) @(posedge clk);
    reset <= 1'h0;
    @(posedge clk);
    t_powerup();
    t_program();
    t_load();
    t_load();
    report_and_stop();
  end
endmodule // serial_config_bitstream_readout_tb_top
`default_nettype wire
